// file: paired_timer_pkg.sv
// Package: constants for the paired 32-bit timer block
// Assumes: control words are 16-bit images driven by the CPU register file outside
package paired_timer_pkg;
	// ----------------------------------------------------------------
	// Control word field positions
	// ----------------------------------------------------------------
	localparam int unsigned CTL_W = 16;
	localparam int unsigned CTL_RUN_BIT = 15;
	localparam int unsigned CTL_IDLE_STOP_BIT = 13;
	localparam int unsigned CTL_GATE_BIT = 6;
	localparam int unsigned CTL_PRE_HI_BIT = 5;
	localparam int unsigned CTL_PRE_LO_BIT = 4;
	localparam int unsigned CTL_JOIN_BIT = 3;
	localparam int unsigned CTL_EXT_CLK_BIT = 1;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] PERIOD_RESET = 16'hffff;
	// ----------------------------------------------------------------
	// Prescaler terminal counts, for dividers 1, 8, 64, 256
	// ----------------------------------------------------------------
	localparam int unsigned PRE_W = 8;
	localparam logic [7:0] PRE_DIV1 = 8'h00;
	localparam logic [7:0] PRE_DIV8 = 8'h07;
	localparam logic [7:0] PRE_DIV64 = 8'h3f;
	localparam logic [7:0] PRE_DIV256 = 8'hff;
	localparam int unsigned TIMERS = 4;
	// Timer activity in the low-power states
	typedef enum logic [1:0] {
		PWR_RUN,
		PWR_IDLE,
		PWR_SLEEP
	} power_state_t;
endpackage

// file: tick_source.sv
// Module: count-enable source of one timer (clock select, sync, gate, prescale)
// Assumes: ext_count and gate_in are synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module tick_source
	import paired_timer_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Settings
	input wire logic run,
	input wire logic ext_clk,
	input wire logic gate_en,
	input wire logic [1:0] pre_sel,
	// Inputs
	input wire logic ext_count,
	input wire logic gate_in,
	// Result
	output logic tick,
	output logic gate_fall
);
	logic ext_d_r;
	logic gate_d_r;
	logic [PRE_W-1:0] pre_r;
	logic [PRE_W-1:0] pre_top;
	logic raw;

	// Prescaler terminal count
	always_comb begin
		case (pre_sel)
			2'b00: pre_top = PRE_DIV1;
			2'b01: pre_top = PRE_DIV8;
			2'b10: pre_top = PRE_DIV64;
			default: pre_top = PRE_DIV256;
		endcase
	end

	// Synchronous edge detect of count input and gate
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ext_d_r <= 1'b0;
			gate_d_r <= 1'b0;
		end else begin
			ext_d_r <= ext_count;
			gate_d_r <= gate_in;
		end
	end

	// Raw event: rising count edge, gate high, or every clock
	always_comb begin
		if (gate_en && !ext_clk)
			raw = gate_in;
		else if (ext_clk)
			raw = ext_count && !ext_d_r;
		else
			raw = 1'b1;
	end

	assign gate_fall = gate_en && !ext_clk && gate_d_r && !gate_in;

	// Prescaler divides raw events
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pre_r <= '0;
		end else if (!run) begin
			pre_r <= '0;
		end else if (raw) begin
			pre_r <= (pre_r >= pre_top) ? '0 : pre_r + 1'b1;
		end
	end

	assign tick = run && raw && (pre_r >= pre_top);
endmodule
`default_nettype wire

// file: timer_half.sv
// Module: one 16-bit count register with write, clear and all-ones flag
// Assumes: inc and clear come from the pair logic
`timescale 1ns/1ps
`default_nettype none
module timer_half
	import paired_timer_pkg::*;
#(
	parameter int unsigned W = 16
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Control
	input wire logic inc,
	input wire logic clear,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	// State
	output logic [W-1:0] count,
	output logic all_ones
);
	logic [W-1:0] count_r;

	// Count, reload or write
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			count_r <= W'(COUNT_RESET);
		else if (load)
			count_r <= load_val;
		else if (clear)
			count_r <= '0;
		else if (inc)
			count_r <= count_r + 1'b1;
	end

	assign count = count_r;
	assign all_ones = &count_r;
endmodule
`default_nettype wire

// file: paired_timer_32bit.sv
// Module: two timer pairs, each two 16-bit timers or one 32-bit timer
// Assumes: control and period words come from the CPU register file;
// count writes arrive as one-cycle strobes; all inputs synchronous
// Function
// - Two pairs, 32-bit or two 16-bit each
// - Split timers do all synchronous 16-bit modes
// - Joined pair is 32-bit timer or synchronised counter
// - Each 16-bit timer is synchronous timer or counter
// - Low timer is low word, high is high
// - Joined pair ignores high control, uses low
// - Joined uses low clock/gate, high flag
// - Interrupt when 32-bit count matches 32-bit period
// - Converter trigger only from first pair
// - Every timer can trigger DMA transfer
// - Timers give capture/compare time base
// - Timers may run in Idle and Sleep
`timescale 1ns/1ps
`default_nettype none
module paired_timer_32bit
	import paired_timer_pkg::*;
#(
	parameter int unsigned N = TIMERS
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Control words: pair_a_low, pair_a_high, pair_b_low, pair_b_high
	input wire logic [CTL_W-1:0] pair_a_low_control,
	input wire logic [CTL_W-1:0] pair_a_high_control,
	input wire logic [CTL_W-1:0] pair_b_low_control,
	input wire logic [CTL_W-1:0] pair_b_high_control,
	// Period words, one per timer
	input wire logic [N*16-1:0] period,
	// Count writes, one strobe per timer
	input wire logic [N-1:0] count_we,
	input wire logic [15:0] count_wdata,
	// External count and gate pins, one per timer
	input wire logic [N-1:0] ext_count,
	input wire logic [N-1:0] gate_in,
	// Device power state
	input wire logic [1:0] power_state,
	// Count values, time base for capture and compare
	output logic [N*16-1:0] count,
	// Period-match flag pulses
	output logic [N-1:0] irq_flag,
	// DMA trigger pulses
	output logic [N-1:0] dma_trig,
	// Converter trigger pulse
	output logic converter_one_trig
);
	// ----------------------------------------------------------------
	// Control decoding
	// ----------------------------------------------------------------
	logic [CTL_W-1:0] ctl [N];
	logic [N-1:0] joined;
	logic [N-1:0] run;
	logic [N-1:0] tick;
	logic [N-1:0] gfall;
	logic [N-1:0] inc;
	logic [N-1:0] clr;
	logic [N-1:0] ones;
	logic [N-1:0] match;
	logic [15:0] cnt [N];
	logic [15:0] per [N];
	logic [N*16-1:0] count_r;
	logic [N-1:0] irq_r;
	logic [N-1:0] dma_r;
	logic conv_r;

	assign ctl[0] = pair_a_low_control;
	assign ctl[1] = pair_a_high_control;
	assign ctl[2] = pair_b_low_control;
	assign ctl[3] = pair_b_high_control;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_tmr
			localparam int unsigned LO = i - (i % 2);
			logic [CTL_W-1:0] eff;
			logic stopped;
			// Joined pair: high timer follows low timer's control
			assign joined[i] = ctl[LO][CTL_JOIN_BIT];
			assign eff = joined[i] ? ctl[LO] : ctl[i];
			// Idle stop bit halts timer in Idle; Sleep keeps running
			// only with the external count input as source
			assign stopped = (power_state == 2'(PWR_IDLE) && eff[CTL_IDLE_STOP_BIT])
				|| (power_state == 2'(PWR_SLEEP) && !eff[CTL_EXT_CLK_BIT]);
			assign run[i] = eff[CTL_RUN_BIT] && !stopped;
			assign per[i] = period[i*16 +: 16];

			// Clock source, gate and prescaler of this timer
			tick_source u_src (
				.clock(clock),
				.reset_n(reset_n),
				.run(run[i]),
				.ext_clk(eff[CTL_EXT_CLK_BIT]),
				.gate_en(eff[CTL_GATE_BIT]),
				.pre_sel(eff[CTL_PRE_HI_BIT:CTL_PRE_LO_BIT]),
				.ext_count(ext_count[LO + (joined[i] ? 0 : i - LO)]),
				.gate_in(gate_in[LO + (joined[i] ? 0 : i - LO)]),
				.tick(tick[i]),
				.gate_fall(gfall[i])
			);

			// Counting register
			timer_half u_half (
				.clock(clock),
				.reset_n(reset_n),
				.inc(inc[i]),
				.clear(clr[i]),
				.load(count_we[i]),
				.load_val(count_wdata),
				.count(cnt[i]),
				.all_ones(ones[i])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pair sequencing: split or joined
	// ----------------------------------------------------------------
	generate
		for (i = 0; i < N; i += 2) begin : g_pair
			logic mode_tick;
			logic edge_ev;
			logic wide_match;
			logic lo_gated;
			// Joined mode takes tick from low source only
			assign mode_tick = tick[i];
			assign lo_gated = ctl[i][CTL_GATE_BIT] && !ctl[i][CTL_EXT_CLK_BIT];
			// Full 32-bit compare, low word from low timer
			assign wide_match = (cnt[i] == per[i]) && (cnt[i+1] == per[i+1]);
			always_comb begin
				if (joined[i]) begin
					// Gated mode: event on gate fall; else on count reaching period
					edge_ev = lo_gated ? gfall[i] : (mode_tick && wide_match);
					inc[i] = mode_tick && !wide_match;
					inc[i+1] = mode_tick && !wide_match && ones[i];
					clr[i] = mode_tick && wide_match;
					clr[i+1] = mode_tick && wide_match;
					match[i] = 1'b0;
					match[i+1] = edge_ev;
				end else begin
					inc[i] = tick[i] && (cnt[i] != per[i]);
					inc[i+1] = tick[i+1] && (cnt[i+1] != per[i+1]);
					clr[i] = tick[i] && (cnt[i] == per[i]);
					clr[i+1] = tick[i+1] && (cnt[i+1] == per[i+1]);
					match[i] = (ctl[i][CTL_GATE_BIT] && !ctl[i][CTL_EXT_CLK_BIT]) ? gfall[i]
						: clr[i];
					match[i+1] = (ctl[i+1][CTL_GATE_BIT] && !ctl[i+1][CTL_EXT_CLK_BIT])
						? gfall[i+1] : clr[i+1];
					edge_ev = 1'b0;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	// Count image for capture and compare modules
	generate
		for (i = 0; i < N; i++) begin : g_out
			assign count_r[i*16 +: 16] = cnt[i];
		end
	endgenerate

	// Time base follows the count registers directly
	assign count = count_r;

	// Interrupt flag and DMA trigger pulses
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_r <= '0;
			dma_r <= '0;
		end else begin
			irq_r <= match;
			dma_r <= match;
		end
	end

	// Converter trigger from first pair only; joined uses its high flag
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			conv_r <= 1'b0;
		else
			conv_r <= joined[0] ? match[1] : match[0];
	end

	assign irq_flag = irq_r;
	assign dma_trig = dma_r;
	assign converter_one_trig = conv_r;
endmodule
`default_nettype wire

// file: paired_timer_checker.sv
// Checker: timing relations at the ports of the paired timer block
// Assumes: bound onto every instance of paired_timer_32bit
`timescale 1ns/1ps
`default_nettype none
module paired_timer_checker
	import paired_timer_pkg::*;
#(
	parameter int unsigned N = TIMERS
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Settings and stimulus
	input wire logic [CTL_W-1:0] pair_a_low_control,
	input wire logic [CTL_W-1:0] pair_a_high_control,
	input wire logic [CTL_W-1:0] pair_b_low_control,
	input wire logic [CTL_W-1:0] pair_b_high_control,
	input wire logic [N*16-1:0] period,
	input wire logic [N-1:0] count_we,
	input wire logic [15:0] count_wdata,
	input wire logic [N-1:0] ext_count,
	input wire logic [N-1:0] gate_in,
	input wire logic [1:0] power_state,
	// Results
	input wire logic [N*16-1:0] count,
	input wire logic [N-1:0] irq_flag,
	input wire logic [N-1:0] dma_trig,
	input wire logic converter_one_trig
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	// Plain running setups of pair A, no write pending
	wire a_plain = pair_a_low_control == 16'h8000 && power_state == 2'h0 && !count_we[0];
	wire a_join = pair_a_low_control == 16'h8008 && power_state == 2'h0 && count_we[1:0] == 2'h0;
	// Count back at zero, flag within one more cycle
	sequence wrap_lo;
		count[15:0] == 16'h0000 ##[0:1] irq_flag[0];
	endsequence
	sequence wrap_wide;
		count[31:0] == 32'h0 ##[0:1] irq_flag[1];
	endsequence
	// ----
	// Assertions
	// ----
	dma_copy_a: assert property (dma_trig == irq_flag)
		else $error("dma trigger differs from flag");
	conv_source_a: assert property (converter_one_trig |->
		irq_flag[1:0] != 2'h0 || $past(irq_flag[1:0]) != 2'h0) else $error("stray converter pulse");
	join_quiet_a: assert property (pair_a_low_control[CTL_JOIN_BIT] &&
		$past(pair_a_low_control[CTL_JOIN_BIT], 2) |-> !irq_flag[0]) else $error("low flag when joined");
	run_hold_a: assert property (!pair_a_low_control[CTL_RUN_BIT] && !count_we[0]
		|=> $stable(count[15:0])) else $error("stopped timer moved");
	load_value_a: assert property (count_we[2] |=> count[47:32] == $past(count_wdata))
		else $error("count write lost");
	split_wrap_a: assert property (a_plain && count[15:0] == period[15:0] |=> wrap_lo)
		else $error("split wrap wrong");
	wide_wrap_a: assert property (a_join && count[31:0] == period[31:0] |=> wrap_wide)
		else $error("joined wrap wrong");
	sleep_hold_a: assert property (power_state == PWR_SLEEP && !count_we[3] &&
		!pair_b_high_control[CTL_EXT_CLK_BIT] && !pair_b_low_control[CTL_EXT_CLK_BIT]
		|=> $stable(count[63:48])) else $error("count moved in sleep");
endmodule
bind paired_timer_32bit paired_timer_checker #(.N(N)) watch_i (
	.clock, .reset_n, .pair_a_low_control, .pair_a_high_control, .pair_b_low_control,
	.pair_b_high_control, .period, .count_we, .count_wdata, .ext_count, .gate_in,
	.power_state, .count, .irq_flag, .dma_trig, .converter_one_trig
);
`default_nettype wire

// file: testbench.sv
// Testbench: table of timer setups, then write, counter, prescale and gate cases
// Assumes: package, design and checker compiled before this file
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct packed {
		logic [15:0] al, ah, bl, bh;
		logic [63:0] per;
		logic [1:0] pw;
		logic [3:0] ex;
		logic cx;
	} row_t;
	// Setups with the flags and converter pulse they should give
	row_t rows[6] = '{
		'{16'h8000, 16'h8000, 16'h8000, 16'h8000, 64'h0006000500040003, 2'h0, 4'hf, 1'b1},
		'{16'h8008, 16'h0000, 16'h8008, 16'h0000, 64'h0000000700000005, 2'h0, 4'ha, 1'b1},
		'{16'h8008, 16'h0040, 16'h0000, 16'h8000, 64'h0004000000000003, 2'h0, 4'ha, 1'b1},
		'{16'h0000, 16'h8000, 16'h8008, 16'h0000, 64'h0000000200030003, 2'h0, 4'ha, 1'b0},
		'{16'h8000, 16'h8000, 16'h8000, 16'h8000, 64'h0003000300030003, 2'h2, 4'h0, 1'b0},
		'{16'ha000, 16'h8000, 16'h8000, 16'h8000, 64'h0003000300030003, 2'h1, 4'he, 1'b0}
	};
	row_t r = '0;
	logic clock, reset_n, cv, cs;
	logic [3:0] we, ec, gi, irq, dma, seen, ds;
	logic [15:0] wd;
	logic [63:0] cnt;
	int dv[3] = '{8, 64, 256};
	int mismatches = 0;
	int n_compared = 0;
	paired_timer_32bit dut (
		.clock(clock), .reset_n(reset_n), .pair_a_low_control(r.al), .pair_a_high_control(r.ah),
		.pair_b_low_control(r.bl), .pair_b_high_control(r.bh), .period(r.per), .count_we(we),
		.count_wdata(wd), .ext_count(ec), .gate_in(gi), .power_state(r.pw), .count(cnt),
		.irq_flag(irq), .dma_trig(dma), .converter_one_trig(cv)
	);
	// Clock source
	initial begin
		clock = 0;
		forever #12.5 clock = ~clock;
	end
	task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Runs cycles and collects pulses
	task step(input int n);
		repeat (n) begin
			@(negedge clock);
			seen |= irq;
			ds |= dma;
			cs |= cv;
		end
	endtask
	// One-cycle count write, then clears the pulse record
	task load(input logic [3:0] m, input logic [15:0] v);
		we = m;
		wd = v;
		@(negedge clock);
		we = 4'h0;
		seen = 4'h0;
		ds = 4'h0;
		cs = 1'b0;
	endtask
	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		reset_n = 0;
		we = 4'h0;
		ec = 4'h0;
		gi = 4'h0;
		wd = 16'h0000;
		repeat (16) @(negedge clock);
		chk("reset count", 64'h0, cnt);
		reset_n = 1;
		foreach (rows[i]) begin
			r = rows[i];
			load(4'hf, 16'h0000);
			step(100);
			chk("irq", r.ex, seen);
			chk("dma", r.ex, ds);
			chk("conv", r.cx, cs);
		end
		r = '0;
		r.per = '1;
		r.bl = 16'h8000;
		load(4'h4, 16'h1234);
		chk("load", 16'h1234, cnt[47:32]);
		r.bl = 16'h800a;
		load(4'hc, 16'h0000);
		repeat (5) begin
			ec[2] = 1;
			step(2);
			ec[2] = 0;
			step(2);
		end
		chk("ext count", 64'h5, cnt[63:32]);
		r.bl = 16'h0000;
		for (int p = 1; p < 4; p++) begin
			r.al = {1'b1, 9'h0, p[1:0], 4'h0};
			load(4'h1, 16'h0000);
			step(10 * dv[p-1]);
			chk("prescale", 1, cnt[15:0] inside {16'h9, 16'ha});
		end
		r.al = 16'h8040;
		load(4'h1, 16'h0000);
		gi[0] = 1;
		step(6);
		gi[0] = 0;
		step(4);
		chk("gate flag", 1, seen[0]);
		chk("gate count", 1, cnt[15:0] inside {[16'h4:16'h7]});
		give_verdict;
	end
endmodule
`default_nettype wire
